// file: src/acpi_seq_pkg.sv
package acpi_seq_pkg;

  // Clock and timing figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEGLITCH_NS = 2000;
  localparam int SLEEP_DELAY_NS = 200000;
  localparam int ASSESS_NS = 53000000;
  // Least times round up to whole cycles
  localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CYC = (SLEEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ASSESS_CYC = (ASSESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Synchroniser bit positions of the asynchronous pins
  localparam int IX_RAM = 0;
  localparam int IX_OFF = 1;
  localparam int IX_KEEP = 2;
  localparam int IX_AUXM = 3;
  localparam int IX_M3 = 4;
  localparam int IX_M5 = 5;
  localparam int IX_D3UV = 6;
  localparam int IX_D5UV = 7;
  localparam int IX_AUXUV = 8;
  localparam int IX_VIDUV = 9;
  localparam int IX_VIDPG = 10;
  localparam int IX_VIDCT = 11;
  localparam int IX_SS = 12;
  localparam int IX_OT = 13;
  localparam int N_SYNC = 14;
  // Pulled-up pins idle high
  localparam logic [N_SYNC-1:0] SYNC_RST = 14'h000f;

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam int CTRL_SHUT_BIT = 0;
  localparam logic CTRL_RST = 1'b0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_FAULT_BIT = 3;
  localparam int ST_PG_BIT = 4;
  localparam int ST_MAIN_BIT = 5;
  localparam int ST_SS_BIT = 6;

  typedef enum logic [2:0] {
    STC_SHUT = 3'h0,
    STC_S5 = 3'h1,
    STC_S3 = 3'h2,
    STC_ASSESS = 3'h3,
    STC_ACTIVE = 3'h4
  } state_code_e;

  typedef enum {st_shutdown, st_s5, st_s3, st_assess, st_active} pwr_state_e;

endpackage

// file: src/deglitch_if.sv
`timescale 1ns/1ps
interface deglitch_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// file: src/level_deglitch.sv
`timescale 1ns/1ps
module level_deglitch #(
  parameter int STABLE_CYC = acpi_seq_pkg::DEGLITCH_CYC,
  parameter logic RST_LEVEL = 1'b1
) (
  input wire logic clk_sys_in, // System clock
  input wire logic rstn_in, // Async reset, low
  deglitch_if.filt port_io // Synced level in, clean level out
);
  import acpi_seq_pkg::*;

  localparam int CW = $clog2(STABLE_CYC + 1);

  // Refused at elaboration, before any clock runs
  if (STABLE_CYC < 1) begin : g_bad_count
    $error("STABLE_CYC must be at least 1");
  end

  logic [CW-1:0] cnt_reg;
  logic clean_reg;
  wire differs = port_io.raw != clean_reg;
  wire stable_done = differs && (cnt_reg == CW'(STABLE_CYC - 1));

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_reg <= '0;
      clean_reg <= RST_LEVEL;
    end else begin
      cnt_reg <= (differs && !stable_done) ? cnt_reg + 1'b1 : '0;
      if (stable_done) begin
        clean_reg <= port_io.raw;
      end
    end
  end

  assign port_io.clean = clean_reg;

  property p_filter_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    $changed(clean_reg) |-> $past(cnt_reg) == CW'(STABLE_CYC - 1);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("Filtered level changed before stability count");

endmodule

// file: src/acpi_sleep_rail_sequencer.sv
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
// Behaviour
// - Both sleep requests are filtered; pulses under about 2 us are ignored.
// - Suspend request low in the active state starts a 200 us timer before sleep entry.
// - At timer expiry go S5 if soft-off low, else S3.
// - S4/S5 to S3 is refused; S3 to S4/S5 is allowed.
// - Otherwise only active-to-sleep and sleep-to-active moves are taken.
// - Soft-off low with suspend high is illegal; state is kept.
// - Standby 3.3 V base drive is on in every sleep state.
// - Main-rail switch output is released in the active state.
// - Standby 5 V switch on in S3; in S5 only with keep strap high.
// - VID regulator enabled only when active.
// - Aux rail on when active; in sleep follows the rail-mode strap.
// - VID good held low while VID rail below its threshold.
// - VID good released only after the capacitor delay trips.
// - Soft-start pin low shuts all outputs and forces fault low.
// - Standby rails start right after power-on reset.
// - Active entered only with both main inputs good.
// - Main input loss while running forces S5.
// - From forced S5, return to active once main inputs recover.
// - Dual 3.3 V rail undervoltage is watched in every state.
// - Fault high on output undervoltage, main input undervoltage while active, or overtemperature.
// - Active declared about 53 ms after main inputs are good.
module acpi_sleep_rail_sequencer #(
  parameter int SLEEP_CYC = acpi_seq_pkg::SLEEP_CYC,
  parameter int ASSESS_CYC = acpi_seq_pkg::ASSESS_CYC,
  parameter int DEGLITCH_CYC = acpi_seq_pkg::DEGLITCH_CYC
) (
  input wire logic clk_sys_in, // 100 MHz clock
  input wire logic rstn_in, // Power-on reset, low
  input wire logic suspend_ram_req_n_in, // Suspend-to-RAM request, low
  input wire logic soft_off_req_n_in, // Soft-off request, low
  input wire logic dual_five_keep_strap_in, // Keep 5 V dual in S5
  input wire logic aux_rail_mode_strap_in, // Aux rail on in sleep
  input wire logic main_three_good_in, // Main 3.3 V above level
  input wire logic main_five_good_in, // Main 5 V above level
  input wire logic dual_three_uv_in, // Dual 3.3 V undervoltage
  input wire logic dual_five_uv_in, // Dual 5 V undervoltage
  input wire logic aux_rail_uv_in, // Aux rail undervoltage
  input wire logic vid_rail_uv_in, // VID rail undervoltage
  input wire logic vid_rail_above_pg_in, // VID rail above good level
  input wire logic vid_good_delay_cap_trip_in, // Delay cap tripped
  input wire logic soft_start_low_in, // Soft-start pin held low
  input wire logic over_temp_in, // Overtemperature flag
  input wire logic [acpi_seq_pkg::ADDR_W-1:0] addr_in, // Register byte address
  input wire logic [acpi_seq_pkg::DATA_W-1:0] wr_data_in, // Write data
  input wire logic wr_en_in, // Write strobe
  input wire logic rd_en_in, // Read strobe
  output logic [acpi_seq_pkg::DATA_W-1:0] rd_data_out, // Read data, next cycle
  output logic standby_three_base_drive_out, // Standby pass base drive
  output logic main_rail_switch_drive_out, // Open-collector level
  output logic main_rail_switch_drive_oe_n_out, // Low pulls switch off
  output logic standby_five_switch_drive_out, // Standby 5 V switch on
  output logic vid_rail_en_out, // VID regulator enable
  output logic aux_rail_gate_en_out, // Aux rail regulator enable
  output logic vid_rail_good_out, // Open-collector level
  output logic vid_rail_good_oe_n_out, // Low holds good low
  output logic fault_out // Fault report, high
);
  import acpi_seq_pkg::*;

  localparam int SW = $clog2(SLEEP_CYC + 1);
  localparam int AW = $clog2(ASSESS_CYC + 1);

  if (SLEEP_CYC < 1 || ASSESS_CYC < 1 || DEGLITCH_CYC < 1) begin : g_bad_counts
    $error("Timing counts must be at least 1");
  end

  function automatic logic [2:0] state_code(input pwr_state_e s);
    case (s)
      st_s5: state_code = STC_S5;
      st_s3: state_code = STC_S3;
      st_assess: state_code = STC_ASSESS;
      st_active: state_code = STC_ACTIVE;
      default: state_code = STC_SHUT;
    endcase
  endfunction

  // Pin synchroniser; only stage two is read
  logic [N_SYNC-1:0] sync1_reg;
  logic [N_SYNC-1:0] sync2_reg;
  wire [N_SYNC-1:0] pins = {over_temp_in, soft_start_low_in, vid_good_delay_cap_trip_in,
    vid_rail_above_pg_in, vid_rail_uv_in, aux_rail_uv_in, dual_five_uv_in, dual_three_uv_in,
    main_five_good_in, main_three_good_in, aux_rail_mode_strap_in, dual_five_keep_strap_in,
    soft_off_req_n_in, suspend_ram_req_n_in};

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // Request filters
  deglitch_if ram_if ();
  deglitch_if off_if ();
  assign ram_if.raw = sync2_reg[IX_RAM];
  assign off_if.raw = sync2_reg[IX_OFF];

  level_deglitch #(.STABLE_CYC(DEGLITCH_CYC), .RST_LEVEL(1'b1)) u_ram_filt (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .port_io(ram_if.filt)
  );
  level_deglitch #(.STABLE_CYC(DEGLITCH_CYC), .RST_LEVEL(1'b1)) u_off_filt (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .port_io(off_if.filt)
  );

  wire ram_n = ram_if.clean;
  wire off_n = off_if.clean;
  wire both_high = ram_n && off_n;
  wire s3_req = off_n && !ram_n;
  wire s5_req = !off_n && !ram_n;
  wire keep_strap = sync2_reg[IX_KEEP];
  wire aux_strap = sync2_reg[IX_AUXM];
  wire main_ok = sync2_reg[IX_M3] && sync2_reg[IX_M5];
  wire ss_low = sync2_reg[IX_SS];

  // Control register
  logic sw_shut_reg;
  logic [DATA_W-1:0] rd_data_reg;
  wire sel_ctrl = addr_in == CTRL_OFS;
  wire sel_status = addr_in == STATUS_OFS;

  wire shut = ss_low || sw_shut_reg;

  pwr_state_e state_reg, state_next;
  logic last_s3_reg;
  logic [SW-1:0] sleep_cnt_reg;
  logic [AW-1:0] assess_cnt_reg;

  wire sleep_run = (state_reg == st_active) && !ram_n;
  wire sleep_done = sleep_run && (sleep_cnt_reg == SW'(SLEEP_CYC - 1));
  wire assess_run = (state_reg == st_assess) && both_high && main_ok;
  wire assess_done = assess_run && (assess_cnt_reg == AW'(ASSESS_CYC - 1));

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sleep_cnt_reg <= '0;
      assess_cnt_reg <= '0;
    end else begin
      sleep_cnt_reg <= (sleep_run && !sleep_done) ? sleep_cnt_reg + 1'b1 : '0;
      assess_cnt_reg <= (assess_run && !assess_done) ? assess_cnt_reg + 1'b1 : '0;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_shutdown: begin
        if (!shut) begin
          state_next = st_s5;
        end
      end
      st_s5: begin
        if (both_high) begin
          state_next = st_assess;
        end
      end
      st_s3: begin
        if (both_high) begin
          state_next = st_assess;
        end else if (s5_req) begin
          state_next = st_s5;
        end
      end
      st_assess: begin
        if (assess_done) begin
          state_next = st_active;
        end else if (s5_req) begin
          state_next = st_s5;
        end else if (s3_req) begin
          state_next = last_s3_reg ? st_s3 : st_s5;
        end
      end
      st_active: begin
        if (!main_ok) begin
          state_next = st_s5;
        end else if (sleep_done) begin
          state_next = off_n ? st_s3 : st_s5;
        end
      end
      default: state_next = st_s5;
    endcase
    if (shut) begin
      state_next = st_shutdown;
    end
  end

  // Reset lands in S5 so standby rails start at once
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= st_s5;
      last_s3_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == st_s3 || state_reg == st_s5) begin
        last_s3_reg <= state_reg == st_s3;
      end
    end
  end

  // Rail decode; a pending wake keeps the previous sleep rails
  wire is_active = state_reg == st_active;
  wire sleep_like = (state_reg == st_s3) || (state_reg == st_s5) || (state_reg == st_assess);
  wire s3_like = (state_reg == st_s3) || ((state_reg == st_assess) && last_s3_reg);
  wire s5_like = sleep_like && !s3_like;
  wire three_base_next = !shut && sleep_like;
  wire main_release_next = !shut && is_active;
  wire five_next = !shut && (s3_like || (s5_like && keep_strap));
  wire vid_en_next = !shut && is_active;
  wire aux_next = !shut && (is_active || (sleep_like && aux_strap));
  // Good needs level and cap delay
  wire vid_rail_good_ok = vid_rail_en_out && sync2_reg[IX_VIDPG] && sync2_reg[IX_VIDCT];
  wire pg_release_next = !shut && vid_rail_good_ok;
  wire out_uv = sync2_reg[IX_D3UV] || (standby_five_switch_drive_out && sync2_reg[IX_D5UV])
    || (aux_rail_gate_en_out && sync2_reg[IX_AUXUV])
    || (vid_rail_en_out && sync2_reg[IX_VIDUV]);
  wire fault_next = !shut && (out_uv || (is_active && !main_ok) || sync2_reg[IX_OT]);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      standby_three_base_drive_out <= 1'b0;
      main_rail_switch_drive_out <= 1'b0;
      main_rail_switch_drive_oe_n_out <= 1'b0;
      standby_five_switch_drive_out <= 1'b0;
      vid_rail_en_out <= 1'b0;
      aux_rail_gate_en_out <= 1'b0;
      vid_rail_good_out <= 1'b0;
      vid_rail_good_oe_n_out <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      standby_three_base_drive_out <= three_base_next;
      main_rail_switch_drive_oe_n_out <= main_release_next;
      standby_five_switch_drive_out <= five_next;
      vid_rail_en_out <= vid_en_next;
      aux_rail_gate_en_out <= aux_next;
      vid_rail_good_oe_n_out <= pg_release_next;
      fault_out <= fault_next;
    end
  end

  // Register port; unmapped reads return zero
  wire [DATA_W-1:0] status_word = {{(DATA_W - 7){1'b0}}, ss_low, main_ok,
    vid_rail_good_oe_n_out, fault_out, state_code(state_reg)};
  wire [DATA_W-1:0] rd_mux = sel_ctrl ? {{(DATA_W - 1){1'b0}}, sw_shut_reg}
    : (sel_status ? status_word : '0);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sw_shut_reg <= CTRL_RST;
      rd_data_reg <= '0;
    end else begin
      if (wr_en_in && sel_ctrl) begin
        sw_shut_reg <= wr_data_in[CTRL_SHUT_BIT];
      end
      rd_data_reg <= rd_en_in ? rd_mux : '0;
    end
  end

  assign rd_data_out = rd_data_reg;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  property p_no_s5_to_s3;
    state_reg == st_s5 |=> state_reg != st_s3;
  endproperty
  a_no_s5_to_s3: assert property (p_no_s5_to_s3)
    else $error("S5 moved straight to S3");

  property p_s3_exits;
    state_reg == st_s3 |=> state_reg != st_active;
  endproperty
  a_s3_exits: assert property (p_s3_exits)
    else $error("S3 reached active without assessment");

  property p_hold_illegal;
    (state_reg == st_s3) && !off_n && ram_n && !shut |=> state_reg == st_s3;
  endproperty
  a_hold_illegal: assert property (p_hold_illegal)
    else $error("Illegal request combination changed state");

  property p_sleep_wait;
    is_active && main_ok && !shut && !sleep_done |=> state_reg == st_active;
  endproperty
  a_sleep_wait: assert property (p_sleep_wait)
    else $error("Active left before sleep timer expired");

  property p_sleep_pick;
    is_active && main_ok && !shut && sleep_done |=> state_reg == (off_n ? st_s3 : st_s5);
  endproperty
  a_sleep_pick: assert property (p_sleep_pick)
    else $error("Wrong sleep state at timer expiry");

  property p_forced_s5;
    is_active && !main_ok && !shut |=> state_reg == st_s5;
  endproperty
  a_forced_s5: assert property (p_forced_s5)
    else $error("Main input loss did not force S5");

  property p_active_entry;
    $rose(state_reg == st_active) |-> $past(state_reg) == st_assess && $past(assess_done);
  endproperty
  a_active_entry: assert property (p_active_entry)
    else $error("Active entered without assessment time");

  property p_vid_only_active;
    (state_reg != st_active) |=> !vid_rail_en_out ##1 !vid_rail_good_oe_n_out;
  endproperty
  a_vid_only_active: assert property (p_vid_only_active)
    else $error("VID enabled or good outside active");

  property p_pg_low;
    !sync2_reg[IX_VIDPG] |=> !vid_rail_good_oe_n_out;
  endproperty
  a_pg_low: assert property (p_pg_low)
    else $error("VID good released below threshold");

  property p_shutdown;
    ss_low |=> !fault_out && !standby_three_base_drive_out && !aux_rail_gate_en_out
      && !standby_five_switch_drive_out && !main_rail_switch_drive_oe_n_out;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("Outputs not off while soft-start held low");

  property p_five_s5;
    (state_reg == st_s5) && !shut |=> standby_five_switch_drive_out == $past(keep_strap);
  endproperty
  a_five_s5: assert property (p_five_s5)
    else $error("Standby 5 V switch wrong in S5");

  property p_aux_sleep;
    (state_reg == st_s3) && !shut |=> aux_rail_gate_en_out == $past(aux_strap);
  endproperty
  a_aux_sleep: assert property (p_aux_sleep)
    else $error("Aux rail wrong in S3");

  c_enter_s3: cover property ((state_reg == st_active) ##1 (state_reg == st_s3));
  c_s3_to_s5: cover property ((state_reg == st_s3) ##1 (state_reg == st_s5));
  c_wake: cover property ((state_reg == st_assess) ##1 (state_reg == st_active));
  c_shutdown: cover property ((state_reg == st_active) ##1 (state_reg == st_shutdown));

endmodule

// file: tb/sleep_host_model.sv
`timescale 1ns/1ps
module sleep_host_model (
  input wire logic clk_sys_in, // System clock
  input wire logic [1:0] cmd_in, // 0 run, 1 to RAM, 2 off, 3 bad pair
  output logic suspend_ram_req_n_out, // Suspend-to-RAM request pin
  output logic soft_off_req_n_out // Soft-off request pin
);
  always_ff @(posedge clk_sys_in) begin
    suspend_ram_req_n_out <= !(cmd_in == 2'h1 || cmd_in == 2'h2);
    soft_off_req_n_out <= !cmd_in[1];
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, s); end end
module tb_top;
  import acpi_seq_pkg::*;
  localparam int SLP = 16;
  localparam int ASS = 32;
  localparam int DGL = 4;
  int err_total = 0;
  int compares = 0;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic ram_n, off_n;
  logic keep = 1'b0, auxm = 1'b0, m3 = 1'b1, m5 = 1'b1;
  logic d3uv = 1'b0, d5uv = 1'b0, auxuv = 1'b0, viduv = 1'b0;
  logic vpg = 1'b0, vct = 1'b0, ss = 1'b0, ot = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic wen = 1'b0, ren = 1'b0;
  logic [31:0] rdat;
  logic base, msw, msw_oen, five, vid_en, aux_en, vgood, vgood_oen, fault;
  wire [4:0] outs = {base, msw_oen, five, vid_en, aux_en};

  always #5 clk_sys_in = ~clk_sys_in;

  sleep_host_model host (.clk_sys_in(clk_sys_in), .cmd_in(cmd),
    .suspend_ram_req_n_out(ram_n), .soft_off_req_n_out(off_n));

  acpi_sleep_rail_sequencer #(.SLEEP_CYC(SLP), .ASSESS_CYC(ASS), .DEGLITCH_CYC(DGL)) dut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .suspend_ram_req_n_in(ram_n), .soft_off_req_n_in(off_n),
    .dual_five_keep_strap_in(keep), .aux_rail_mode_strap_in(auxm),
    .main_three_good_in(m3), .main_five_good_in(m5),
    .dual_three_uv_in(d3uv), .dual_five_uv_in(d5uv),
    .aux_rail_uv_in(auxuv), .vid_rail_uv_in(viduv),
    .vid_rail_above_pg_in(vpg), .vid_good_delay_cap_trip_in(vct),
    .soft_start_low_in(ss), .over_temp_in(ot),
    .addr_in(addr), .wr_data_in(wdat), .wr_en_in(wen), .rd_en_in(ren),
    .rd_data_out(rdat), .standby_three_base_drive_out(base),
    .main_rail_switch_drive_out(msw), .main_rail_switch_drive_oe_n_out(msw_oen),
    .standby_five_switch_drive_out(five), .vid_rail_en_out(vid_en),
    .aux_rail_gate_en_out(aux_en), .vid_rail_good_out(vgood),
    .vid_rail_good_oe_n_out(vgood_oen), .fault_out(fault));

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdat <= d;
    wen <= 1'b1;
    @(posedge clk_sys_in);
    wen <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    ren <= 1'b1;
    @(posedge clk_sys_in);
    ren <= 1'b0;
    #1 d = rdat;
  endtask

  // Polls state; bound keeps a stuck design from hanging here
  task automatic wait_st(input logic [2:0] c, input int n);
    logic [31:0] d;
    for (int i = 0; i < n; i++) begin
      rd(STATUS_OFS, d);
      if (d[ST_STATE_LSB +: 3] === c) break;
    end
    `CHK("state", c, d[ST_STATE_LSB +: 3])
  endtask

  task automatic not_active;
    logic [31:0] d;
    rd(STATUS_OFS, d);
    `CHK("not_active", 1'b0, d[ST_STATE_LSB +: 3] === STC_ACTIVE)
  endtask

  task automatic chk_outs(input logic [4:0] e);
    cyc(3);
    #1 `CHK("rails", e, outs)
    `CHK("level_pins", 2'b00, {msw, vgood})
  endtask

  task automatic t_powerup;
    cyc(12);
    rstn_in <= 1'b1;
    cyc(3);
    #1 `CHK("base_drive", 1'b1, base)
    cyc(16);
    not_active();
    wait_st(STC_ACTIVE, 40);
    chk_outs(5'b01011);
  endtask

  task automatic t_vid;
    cyc(8);
    #1 `CHK("vid_good_low", 1'b0, vgood_oen)
    vpg <= 1'b1;
    cyc(8);
    #1 `CHK("vid_good_wait", 1'b0, vgood_oen)
    vct <= 1'b1;
    cyc(8);
    #1 `CHK("vid_good_rel", 1'b1, vgood_oen)
    vpg <= 1'b0;
    vct <= 1'b0;
    cyc(8);
    #1 `CHK("vid_good_drop", 1'b0, vgood_oen)
  endtask

  task automatic t_glitch;
    @(posedge clk_sys_in);
    cmd <= 2'h1;
    cyc(DGL - 1);
    cmd <= 2'h0;
    cyc(SLP + 20);
    wait_st(STC_ACTIVE, 1);
  endtask

  task automatic t_illegal;
    cmd <= 2'h3;
    cyc(SLP + 30);
    wait_st(STC_ACTIVE, 1);
    cmd <= 2'h0;
    cyc(10);
  endtask

  task automatic t_sleep;
    cmd <= 2'h1;
    cyc(SLP);
    wait_st(STC_ACTIVE, 1);
    wait_st(STC_S3, 30);
    chk_outs(5'b10100);
    // Short soft-off pulse must not deepen S3
    cmd <= 2'h2;
    cyc(DGL - 1);
    cmd <= 2'h1;
    cyc(10);
    wait_st(STC_S3, 1);
    cmd <= 2'h2;
    wait_st(STC_S5, 30);
    chk_outs(5'b10000);
    cmd <= 2'h1;
    cyc(SLP + 30);
    wait_st(STC_S5, 1);
    cmd <= 2'h0;
    wait_st(STC_ACTIVE, 40);
  endtask

  task automatic t_straps;
    keep <= 1'b1;
    auxm <= 1'b1;
    cmd <= 2'h2;
    wait_st(STC_S5, 40);
    chk_outs(5'b10101);
    cmd <= 2'h0;
    wait_st(STC_ACTIVE, 40);
  endtask

  task automatic t_main_loss;
    m3 <= 1'b0;
    wait_st(STC_S5, 10);
    m3 <= 1'b1;
    m5 <= 1'b0;
    cyc(ASS + 20);
    not_active();
    m5 <= 1'b1;
    wait_st(STC_ACTIVE, 40);
  endtask

  task automatic t_fault;
    for (int i = 0; i < 2; i++) begin
      {ot, d3uv} <= (i == 0) ? 2'b01 : 2'b10;
      cyc(6);
      #1 `CHK("fault_set", 1'b1, fault)
      {ot, d3uv} <= 2'b00;
      cyc(6);
      #1 `CHK("fault_clr", 1'b0, fault)
    end
  endtask

  task automatic t_shut;
    logic [31:0] d;
    d3uv <= 1'b1;
    ss <= 1'b1;
    cyc(6);
    #1 `CHK("rails_off", 5'b00000, outs)
    `CHK("fault_off", 1'b0, fault)
    rd(STATUS_OFS, d);
    `CHK("ss_status", 1'b1, d[ST_SS_BIT])
    ss <= 1'b0;
    d3uv <= 1'b0;
    wait_st(STC_ACTIVE, 60);
    wr(CTRL_OFS, 32'h1);
    wait_st(STC_SHUT, 4);
    rd(CTRL_OFS, d);
    `CHK("ctrl_shut", 32'h1, d)
    wr(CTRL_OFS, 32'h0);
    wait_st(STC_ACTIVE, 60);
    rd(4'h8, d);
    `CHK("unmapped", 32'h0, d)
    wr(STATUS_OFS, 32'hffffffff);
    wait_st(STC_ACTIVE, 1);
  endtask

  initial begin
    t_powerup();
    t_vid();
    t_glitch();
    t_illegal();
    t_sleep();
    t_straps();
    t_main_loss();
    t_fault();
    t_shut();
    complete_run();
  end

  // Whole run is several hundred cycles
  initial begin
    cyc(20000);
    err_total++;
    $display("MISMATCH watchdog expected done seen hang");
    complete_run();
  end
endmodule
